// File: link_irq_regs.svh
`ifndef LINK_IRQ_REGS_SVH
`define LINK_IRQ_REGS_SVH

`define STATUS_OFFSET 8'h00
`define MASK_OFFSET 8'h04
`define CONTROL_OFFSET 8'h08
`define STATE_OFFSET 8'h0C

`define RX_DATA_BIT 6
`define CMD_RESET_BIT 7
`define ACK_RCV_BIT 8
`define ISO_BAD_BIT 11
`define ASYNC_BAD_BIT 12
`define BUSY_ACK_BIT 14
`define HDR_ERR_BIT 15
`define TCODE_ERR_BIT 16
`define CYCLE_TMO_BIT 19
`define STATUS_IMPL_MASK 32'h0009_D9C0

`define CTRL_TRIGGER_BIT 0
`define CTRL_ASYNC_CLR_BIT 1
`define CTRL_GRF_CLR_BIT 2

`define STATE_ASYNC_BAD_BIT 0
`define STATE_OVERFLOW_BIT 1
`define STATE_SID_PEND_BIT 2
`define STATE_ACK_WAIT_BIT 3

`define STATUS_RESET 32'h0000_0000
`define MASK_RESET 32'h0000_0000

`define CLK_PERIOD_NS 10
`define CYCLE_TIME_NS 125000
`define CYCLE_LIMIT_CYCLES (`CYCLE_TIME_NS / `CLK_PERIOD_NS)

`define RESET_START_ADDR 48'hFFFF_F000_000C

`endif

// File: link_irq_pkg.sv
package link_irq_pkg;

  typedef enum logic [1:0] {
    resp_okay = 2'b00,
    resp_slverr = 2'b10
  } axi_resp_type;

  typedef struct packed {
    logic [31:0] count;
    logic running;
    logic overrun;
  } timer_state_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    axi_resp_type bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    axi_resp_type rresp;
    logic [31:0] status;
    logic [31:0] mask;
    logic trigger_mode_enable;
    logic async_bad_state;
    logic overflow_state;
    logic sid_pending;
    logic ack_waiting;
    logic irq;
    logic async_tx_enable;
    logic iso_tx_enable;
    logic rx_force_busy_ack;
    logic rx_drop_packet;
    logic async_fifo_clear;
    logic grf_clear;
  } link_state_type;

endpackage

// File: cycle_overrun_timer.sv
`timescale 1ns/1ns
`include "link_irq_regs.svh"

module cycle_overrun_timer
  import link_irq_pkg::*;
#(
  parameter int unsigned LIMIT = `CYCLE_LIMIT_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cycle_start,
  input wire logic cycle_end,
  output logic overrun
);

  generate
    if (LIMIT < 2) begin : g_bad_limit
      $error("Cycle limit must be at least two clock cycles.");
    end
  endgenerate

  timer_state_type state;
  timer_state_type next_state;

  always_comb begin
    next_state = state;
    next_state.overrun = 1'b0;
    if (cycle_start) begin
      next_state.running = 1'b1;
      next_state.count = 32'h0000_0001;
    end else if (cycle_end) begin
      next_state.running = 1'b0;
    end else if (state.running) begin
      next_state.count = state.count + 32'h0000_0001;
      // Stop counting at the limit so one overrun gives one pulse.
      if (state.count == LIMIT) begin
        next_state.overrun = 1'b1;
        next_state.running = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign overrun = state.overrun;

endmodule

// File: link_layer_interrupt_status.sv
// Overview of operation
// - Receive-data flag when packet stored outside trigger mode, or when block stored in trigger mode.
// - During self-ID, flag after bus reset completes.
// - Command-reset flag on reset-start quadlet write.
// - Ack flag on acknowledge or ack timeout.
// - Iso bad-format flag on invalid iso data.
// - Async bad-format flag on invalid async data.
// - Missing first-quadlet entry enters async bad state.
// - Async FIFO underflow enters async bad state.
// - Bad state blocks async until FIFO clear.
// - Isochronous transmission continues during bad state.
// - Busy-ack flag on receive FIFO overflow.
// - After overflow, answer busy acknowledge.
// - Header-error flag on header CRC mismatch.
// - Drop packets failing header CRC.
// - Tcode-error flag on invalid transaction code.
// - Cycle-timeout flag after 125 us cycle.
`timescale 1ns/1ns
`include "link_irq_regs.svh"

module link_layer_interrupt_status
  import link_irq_pkg::*;
#(
  parameter int unsigned CYCLE_LIMIT = `CYCLE_LIMIT_CYCLES,
  parameter logic [47:0] RESET_START_ADDR = `RESET_START_ADDR
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_block_stored,
  input wire logic rx_packet_stored,
  input wire logic self_id_phase,
  input wire logic bus_reset_done,
  input wire logic rx_quadlet_write,
  input wire logic rx_for_this_node,
  input wire logic [47:0] rx_dest_offset,
  input wire logic async_tx_sent,
  input wire logic ack_arrived,
  input wire logic ack_timeout,
  input wire logic iso_tx_invalid,
  input wire logic async_tx_invalid,
  input wire logic async_tx_head_fetch,
  input wire logic async_tx_head_tagged,
  input wire logic async_tx_underflow,
  input wire logic grf_overflow,
  input wire logic rx_header_crc_bad,
  input wire logic tx_tcode_invalid,
  input wire logic iso_cycle_start,
  input wire logic iso_cycle_end,
  output logic irq,
  output logic trigger_mode_enable,
  output logic async_tx_enable,
  output logic iso_tx_enable,
  output logic rx_force_busy_ack,
  output logic rx_drop_packet,
  output logic async_fifo_clear,
  output logic grf_clear
);

  link_state_type state;
  link_state_type next_state;
  logic cycle_overrun;

  cycle_overrun_timer #(
    .LIMIT(CYCLE_LIMIT)
  ) u_cycle_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .cycle_start(iso_cycle_start),
    .cycle_end(iso_cycle_end),
    .overrun(cycle_overrun)
  );

  function automatic logic [31:0] apply_strobe(
    input logic [31:0] old_value,
    input logic [31:0] new_value,
    input logic [3:0] strobe
  );
    logic [31:0] result;
    result = old_value;
    for (int i = 0; i < 4; i++) begin
      if (strobe[i]) begin
        result[i*8 +: 8] = new_value[i*8 +: 8];
      end
    end
    return result;
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    return (addr == `STATUS_OFFSET) || (addr == `MASK_OFFSET) ||
           (addr == `CONTROL_OFFSET) || (addr == `STATE_OFFSET);
  endfunction

  logic [31:0] events;
  logic [31:0] w1c;
  logic [31:0] wr_value;
  logic do_write;
  logic rx_done;
  logic head_bad;
  logic async_bad_event;
  logic clear_async;
  logic clear_grf;

  always_comb begin
    next_state = state;
    events = 32'h0000_0000;
    w1c = 32'h0000_0000;
    wr_value = apply_strobe(32'h0000_0000, state.wdata, state.wstrb);
    do_write = state.aw_held && state.w_held && !state.bvalid;
    clear_async = 1'b0;
    clear_grf = 1'b0;
    next_state.async_fifo_clear = 1'b0;
    next_state.grf_clear = 1'b0;
    next_state.rx_drop_packet = 1'b0;

    // Write address and data are taken independently and held until both exist.
    if (s_axi_awvalid && state.awready) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
      next_state.awready = 1'b0;
    end
    if (s_axi_wvalid && state.wready) begin
      next_state.w_held = 1'b1;
      next_state.wdata = s_axi_wdata;
      next_state.wstrb = s_axi_wstrb;
      next_state.wready = 1'b0;
    end
    if (do_write) begin
      next_state.bvalid = 1'b1;
      next_state.bresp = is_mapped(state.aw_addr) ? resp_okay : resp_slverr;
      unique case (state.aw_addr)
        `STATUS_OFFSET: w1c = wr_value;
        `MASK_OFFSET: next_state.mask = apply_strobe(state.mask, state.wdata, state.wstrb) & `STATUS_IMPL_MASK;
        `CONTROL_OFFSET: begin
          if (state.wstrb[0]) begin
            next_state.trigger_mode_enable = state.wdata[`CTRL_TRIGGER_BIT];
            clear_async = state.wdata[`CTRL_ASYNC_CLR_BIT];
            clear_grf = state.wdata[`CTRL_GRF_CLR_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
      next_state.aw_held = 1'b0;
      next_state.w_held = 1'b0;
      next_state.awready = 1'b1;
      next_state.wready = 1'b1;
    end

    // Reads answer one cycle after the address is taken.
    if (s_axi_arvalid && state.arready) begin
      next_state.arready = 1'b0;
      next_state.rvalid = 1'b1;
      next_state.rresp = is_mapped(s_axi_araddr) ? resp_okay : resp_slverr;
      unique case (s_axi_araddr)
        `STATUS_OFFSET: next_state.rdata = state.status;
        `MASK_OFFSET: next_state.rdata = state.mask;
        `CONTROL_OFFSET: next_state.rdata = {31'h0000_0000, state.trigger_mode_enable};
        `STATE_OFFSET: next_state.rdata = {28'h000_0000, state.ack_waiting, state.sid_pending,
                                           state.overflow_state, state.async_bad_state};
        default: next_state.rdata = 32'h0000_0000;
      endcase
    end
    if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
      next_state.arready = 1'b1;
    end

    // In trigger mode every stored block counts; otherwise only a whole packet.
    rx_done = state.trigger_mode_enable ? rx_block_stored : rx_packet_stored;
    if (rx_done && self_id_phase) begin
      next_state.sid_pending = 1'b1;
    end else if (rx_done) begin
      events[`RX_DATA_BIT] = 1'b1;
    end
    if (bus_reset_done && (state.sid_pending || (rx_done && self_id_phase))) begin
      events[`RX_DATA_BIT] = 1'b1;
      next_state.sid_pending = 1'b0;
    end

    if (rx_quadlet_write && rx_for_this_node && rx_dest_offset == RESET_START_ADDR) begin
      events[`CMD_RESET_BIT] = 1'b1;
    end

    // The acknowledge flag needs an asynchronous packet sent earlier or in the same cycle.
    if (async_tx_sent) begin
      next_state.ack_waiting = 1'b1;
    end
    if ((state.ack_waiting || async_tx_sent) && (ack_arrived || ack_timeout)) begin
      events[`ACK_RCV_BIT] = 1'b1;
      next_state.ack_waiting = 1'b0;
    end

    events[`ISO_BAD_BIT] = iso_tx_invalid;

    head_bad = async_tx_head_fetch && !async_tx_head_tagged;
    async_bad_event = async_tx_invalid || head_bad || async_tx_underflow;
    events[`ASYNC_BAD_BIT] = async_bad_event;
    // A fault in the same cycle as the clear still leaves the block stopped.
    if (async_bad_event) begin
      next_state.async_bad_state = 1'b1;
    end else if (clear_async) begin
      next_state.async_bad_state = 1'b0;
    end
    if (clear_async) begin
      next_state.async_fifo_clear = 1'b1;
    end
    next_state.async_tx_enable = !next_state.async_bad_state;
    next_state.iso_tx_enable = 1'b1;

    events[`BUSY_ACK_BIT] = grf_overflow;
    if (grf_overflow) begin
      next_state.overflow_state = 1'b1;
    end else if (clear_grf) begin
      next_state.overflow_state = 1'b0;
    end
    if (clear_grf) begin
      next_state.grf_clear = 1'b1;
    end
    next_state.rx_force_busy_ack = next_state.overflow_state;

    events[`HDR_ERR_BIT] = rx_header_crc_bad;
    next_state.rx_drop_packet = rx_header_crc_bad;
    events[`TCODE_ERR_BIT] = tx_tcode_invalid;
    events[`CYCLE_TMO_BIT] = cycle_overrun;

    // A new event wins over a software clear of the same bit.
    next_state.status = ((state.status & ~w1c) | events) & `STATUS_IMPL_MASK;
    next_state.irq = |(next_state.status & next_state.mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
      state.awready <= 1'b1;
      state.wready <= 1'b1;
      state.arready <= 1'b1;
      state.status <= `STATUS_RESET;
      state.mask <= `MASK_RESET;
      state.async_tx_enable <= 1'b1;
      state.iso_tx_enable <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign s_axi_awready = state.awready;
  assign s_axi_wready = state.wready;
  assign s_axi_bvalid = state.bvalid;
  assign s_axi_bresp = state.bresp;
  assign s_axi_arready = state.arready;
  assign s_axi_rvalid = state.rvalid;
  assign s_axi_rdata = state.rdata;
  assign s_axi_rresp = state.rresp;
  assign irq = state.irq;
  assign trigger_mode_enable = state.trigger_mode_enable;
  assign async_tx_enable = state.async_tx_enable;
  assign iso_tx_enable = state.iso_tx_enable;
  assign rx_force_busy_ack = state.rx_force_busy_ack;
  assign rx_drop_packet = state.rx_drop_packet;
  assign async_fifo_clear = state.async_fifo_clear;
  assign grf_clear = state.grf_clear;

endmodule

// File: link_irq_monitor.sv
`timescale 1ns/1ns
module link_irq_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic grf_overflow,
  input wire logic rx_force_busy_ack,
  input wire logic rx_header_crc_bad,
  input wire logic rx_drop_packet,
  input wire logic async_tx_invalid,
  input wire logic async_tx_underflow,
  input wire logic async_tx_enable,
  input wire logic async_fifo_clear,
  input wire logic iso_tx_enable
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence fault_seen;
    async_tx_invalid || async_tx_underflow;
  endsequence
  a_write_answer: assert property (both_taken |=> ##1 s_axi_bvalid) else $error("write response late");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_drop_after_crc: assert property (rx_header_crc_bad |=> rx_drop_packet) else $error("no drop");
  a_drop_only_crc: assert property (rx_drop_packet |-> $past(rx_header_crc_bad)) else $error("stray drop");
  a_async_fault_blocks: assert property (fault_seen |=> !async_tx_enable) else $error("async still on");
  a_async_reopen: assert property ($rose(async_tx_enable) |-> async_fifo_clear || $past(async_fifo_clear)
    || $past(async_fifo_clear, 2)) else $error("async reopened without clear");
  a_iso_always_on: assert property (iso_tx_enable) else $error("iso transmit stopped");
  a_busy_ack_on: assert property (grf_overflow |=> rx_force_busy_ack) else $error("no busy ack");
endmodule
bind link_layer_interrupt_status link_irq_monitor i_mon (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .grf_overflow(grf_overflow), .rx_force_busy_ack(rx_force_busy_ack), .rx_header_crc_bad(rx_header_crc_bad),
  .rx_drop_packet(rx_drop_packet), .async_tx_invalid(async_tx_invalid), .async_tx_underflow(async_tx_underflow),
  .async_tx_enable(async_tx_enable), .async_fifo_clear(async_fifo_clear), .iso_tx_enable(iso_tx_enable));

// File: tb.sv
`timescale 1ns/1ns
module tb;
  import link_irq_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, sid = 0;
  logic awready, wready, bvalid, arready, rvalid, irq, trig, a_en, i_en, busy, drop, a_clr, g_clr;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, r;
  logic [19:0] ev = 0;
  logic [47:0] dest = 48'h0000_0000_0000;
  int num_errors = 0, checked = 0, cyc = 0;
  initial forever #5 aclk = ~aclk;
  // Bench bit n of ev drives the event that sets status bit n where one exists.
  link_layer_interrupt_status #(.CYCLE_LIMIT(20)) i_link_layer_interrupt_status (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'b000), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'b000), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_block_stored(ev[0]),
    .rx_packet_stored(ev[6]), .self_id_phase(sid), .bus_reset_done(ev[2]), .rx_quadlet_write(ev[7]),
    .rx_for_this_node(1'b1), .rx_dest_offset(dest), .async_tx_sent(ev[10]), .ack_arrived(ev[8]),
    .ack_timeout(ev[13]), .iso_tx_invalid(ev[11]), .async_tx_invalid(ev[12]), .async_tx_head_fetch(ev[3]),
    .async_tx_head_tagged(ev[4]), .async_tx_underflow(ev[5]), .grf_overflow(ev[14]),
    .rx_header_crc_bad(ev[15]), .tx_tcode_invalid(ev[16]), .iso_cycle_start(ev[17]),
    .iso_cycle_end(ev[18]), .irq(irq), .trigger_mode_enable(trig), .async_tx_enable(a_en),
    .iso_tx_enable(i_en), .rx_force_busy_ack(busy), .rx_drop_packet(drop), .async_fifo_clear(a_clr),
    .grf_clear(g_clr));
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    fork
      begin do @(posedge aclk); while (!awready); awvalid <= 0; end
      begin do @(posedge aclk); while (!wready); wvalid <= 0; end
    join
    bready <= 1;
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    rready <= 1;
    do @(posedge aclk); while (!rvalid);
    rready <= 0;
    chk(n, rdata, e);
  endtask
  task automatic fire(input logic [19:0] m);
    @(posedge aclk);
    ev <= m;
    @(posedge aclk);
    ev <= 0;
    repeat (2) @(posedge aclk);
  endtask
  task automatic t_regs();
    rc(8'h00, 32'h0000_0000, "status reset");
    rc(8'h10, 32'h0000_0000, "unmapped data");
    chk("unmapped resp", {30'b0, rresp}, 32'h0000_0002);
    wr(8'h10, 32'h0000_0000);
    chk("unmapped bresp", {30'b0, r}, 32'h0000_0002);
    wr(8'h04, 32'hffff_ffff);
    chk("mask bresp", {30'b0, r}, 32'h0000_0000);
    rc(8'h04, 32'h0009_d9c0, "mask layout");
    fire(20'h0_0080);
    rc(8'h00, 32'h0000_0000, "other offset");
    $display("test regs done");
  endtask
  task automatic t_events();
    int bits[8] = '{6, 7, 8, 11, 12, 14, 15, 16};
    dest = 48'hffff_f000_000c;
    foreach (bits[i]) begin
      fire((20'h1 << bits[i]) | (bits[i] == 8 ? 20'h0_0400 : 20'h0));
      rc(8'h00, 32'h1 << bits[i], "event flag");
      chk("irq set", {31'b0, irq}, 32'h1);
      wr(8'h00, 32'h1 << bits[i]);
      chk("irq clear", {31'b0, irq}, 32'h0);
    end
    fire(20'h0_2400);
    rc(8'h00, 32'h0000_0100, "ack timeout");
    wr(8'h00, 32'h0000_0100);
    wr(8'h08, 32'h0000_0006);
    $display("test events done");
  endtask
  task automatic t_async();
    fire(20'h0_0018);
    chk("tagged head", {31'b0, a_en}, 32'h1);
    fire(20'h0_0008);
    chk("untagged head", {31'b0, a_en}, 32'h0);
    chk("iso on", {31'b0, i_en}, 32'h1);
    repeat (6) @(posedge aclk);
    chk("still blocked", {31'b0, a_en}, 32'h0);
    rc(8'h00, 32'h0000_1000, "bad flag");
    wr(8'h08, 32'h0000_0002);
    repeat (2) @(posedge aclk);
    chk("reopened", {31'b0, a_en}, 32'h1);
    fire(20'h0_0020);
    chk("underflow", {31'b0, a_en}, 32'h0);
    wr(8'h08, 32'h0000_0002);
    wr(8'h00, 32'hffff_ffff);
    $display("test async done");
  endtask
  task automatic t_rx();
    fire(20'h0_4000);
    chk("busy ack", {31'b0, busy}, 32'h1);
    rc(8'h0C, 32'h0000_0002, "overflow state");
    wr(8'h08, 32'h0000_0004);
    sid <= 1;
    fire(20'h0_0040);
    rc(8'h00, 32'h0000_4000, "held in self id");
    fire(20'h0_0004);
    sid <= 0;
    rc(8'h00, 32'h0000_4040, "after bus reset");
    wr(8'h00, 32'hffff_ffff);
    wr(8'h08, 32'h0000_0001);
    chk("trigger out", {31'b0, trig}, 32'h1);
    rc(8'h08, 32'h0000_0001, "control read");
    fire(20'h0_0001);
    rc(8'h00, 32'h0000_0040, "trigger block");
    wr(8'h00, 32'hffff_ffff);
    $display("test rx done");
  endtask
  task automatic t_cycle();
    fire(20'h2_0000);
    repeat (25) @(posedge aclk);
    rc(8'h00, 32'h0008_0000, "overrun");
    wr(8'h00, 32'h0008_0000);
    fire(20'h2_0000);
    fire(20'h4_0000);
    repeat (25) @(posedge aclk);
    rc(8'h00, 32'h0000_0000, "short cycle");
    wr(8'h04, 32'h0000_0000);
    fire(20'h0_0400);
    fire(20'h0_0100);
    chk("masked irq", {31'b0, irq}, 32'h0);
    wr(8'h04, 32'h0000_0100);
    chk("unmasked irq", {31'b0, irq}, 32'h1);
    $display("test cycle done");
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    t_regs();
    t_events();
    t_async();
    t_rx();
    t_cycle();
    give_verdict();
  end
endmodule
